//--- logic/pcw_pkg.sv
package pcw_pkg;

  // ------------------------------------------------------------------
  // Widths and address space
  // ------------------------------------------------------------------
  localparam int ADDR_W = 5;
  localparam int DATA_W = 6;
  localparam int EDGE_W = 7;
  localparam int REG_DEPTH = 11;

  localparam logic [4:0] SINK_ENABLE_BITS_ADDR = 5'h00;
  localparam logic [4:0] PRIMARY_BANK_CURRENT_ADDR = 5'h01;
  localparam logic [4:0] SECONDARY_BANK_CURRENT_ADDR = 5'h02;
  localparam logic [4:0] UNUSED_LOW_ADDR = 5'h03;
  localparam logic [4:0] UNUSED_HIGH_ADDR = 5'h04;
  localparam logic [4:0] REGULATOR_ONE_VOLTAGE_ADDR = 5'h05;
  localparam logic [4:0] REGULATOR_TWO_VOLTAGE_ADDR = 5'h06;
  localparam logic [4:0] REGULATOR_THREE_VOLTAGE_ADDR = 5'h07;
  localparam logic [4:0] REGULATOR_FOUR_VOLTAGE_ADDR = 5'h08;
  localparam logic [4:0] BANK_RAMP_CONTROL_ADDR = 5'h09;
  localparam logic [4:0] BANK_ASSIGNMENT_ADDR = 5'h0a;

  localparam logic [5:0] REG_RESET_VALUE = 6'h00;

  // Writable field masks; reserved bits always store zero
  localparam logic [5:0] MASK_NONE = 6'h00;
  localparam logic [5:0] MASK_FULL = 6'h3f;
  localparam logic [5:0] MASK_LEVEL = 6'h1f;
  localparam logic [5:0] MASK_CODE4 = 6'h0f;
  localparam logic [5:0] MASK_CODE3 = 6'h07;

  // ------------------------------------------------------------------
  // Pulse counts: edge count is value plus one
  // ------------------------------------------------------------------
  localparam logic [6:0] EDGE_NONE = 7'h00;
  localparam logic [6:0] ADDR_EDGE_MAX = 7'h20;
  localparam logic [6:0] DATA_EDGE_MAX = 7'h40;

  // ------------------------------------------------------------------
  // Timing, in ns, at a 50 ns clock
  // ------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 50;
  localparam int ENABLE_HIGH_TIME_NS = 100_000;
  localparam int DISABLE_LOW_TIME_NS = 3_000_000;
  localparam int ADDR_HOLD_TIME_MIN_NS = 500_000;
  localparam int ADDR_HOLD_TIME_MAX_NS = 1_000_000;
  localparam int DATA_HOLD_TIME_NS = 500_000;
  localparam int STANDBY_HIGH_TIME_NS = 10_000_000;

  // Least times round up, longest times round down
  localparam int ENABLE_HIGH_CYC =
    (ENABLE_HIGH_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DISABLE_LOW_CYC =
    (DISABLE_LOW_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ADDR_HOLD_MIN_CYC =
    (ADDR_HOLD_TIME_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ADDR_HOLD_MAX_CYC = ADDR_HOLD_TIME_MAX_NS / CLK_PERIOD_NS;
  localparam int DATA_HOLD_CYC =
    (DATA_HOLD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STANDBY_CYC =
    (STANDBY_HIGH_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    PH_ADDR = 2'b01,
    PH_DATA = 2'b10
  } phase_t;

  function automatic logic [5:0] field_mask(input logic [4:0] a);
    case (a)
      SINK_ENABLE_BITS_ADDR: field_mask = MASK_FULL;
      PRIMARY_BANK_CURRENT_ADDR: field_mask = MASK_LEVEL;
      SECONDARY_BANK_CURRENT_ADDR: field_mask = MASK_LEVEL;
      REGULATOR_ONE_VOLTAGE_ADDR: field_mask = MASK_CODE4;
      REGULATOR_TWO_VOLTAGE_ADDR: field_mask = MASK_CODE3;
      REGULATOR_THREE_VOLTAGE_ADDR: field_mask = MASK_CODE4;
      REGULATOR_FOUR_VOLTAGE_ADDR: field_mask = MASK_CODE4;
      BANK_RAMP_CONTROL_ADDR: field_mask = MASK_FULL;
      BANK_ASSIGNMENT_ADDR: field_mask = MASK_CODE3;
      default: field_mask = MASK_NONE;
    endcase
  endfunction

endpackage

//--- logic/ctrl_reg_bank.sv
`timescale 1ns/10ps
module ctrl_reg_bank #(
  parameter int ADDR_W = pcw_pkg::ADDR_W,
  parameter int DATA_W = pcw_pkg::DATA_W,
  parameter int DEPTH = pcw_pkg::REG_DEPTH
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_clear,
  input wire logic i_we,
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [DATA_W-1:0] i_data,
  output logic [DEPTH-1:0][DATA_W-1:0] o_regs
);

  if (ADDR_W != pcw_pkg::ADDR_W || DATA_W != pcw_pkg::DATA_W ||
      DEPTH > (1 << ADDR_W)) begin : g_chk
    $error("ctrl_reg_bank: unsupported geometry");
  end

  // Locations without a field mask are holes; writes there are dropped
  logic hit;
  assign hit = i_we && (pcw_pkg::field_mask(i_addr) != pcw_pkg::MASK_NONE);

  for (genvar g = 0; g < DEPTH; g++) begin : g_loc
    always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
        o_regs[g] <= pcw_pkg::REG_RESET_VALUE;
      end else if (i_clear) begin
        o_regs[g] <= pcw_pkg::REG_RESET_VALUE;
      end else if (hit && i_addr == ADDR_W'(g)) begin
        o_regs[g] <= i_data & pcw_pkg::field_mask(ADDR_W'(g));
      end
    end
  end

endmodule

//--- logic/pulse_count_write_interface.sv
`timescale 1ns/10ps
// Overview of operation
// - Up to 32 addresses; address train, then data.
// - Store data only after data hold interval.
// - Long high enables; long low disables device.
// - Address is edges minus one, taken after hold.
// - Short highs keep accumulating address edges.
// - Address count above 31 discards the command.
// - Overlong address hold abandons the command.
// - Data count above 63 drops the write.
// - After data hold expect an address again.
// - Ten millisecond high returns receiver to standby.
// - Irregular pulse widths do not corrupt transfers.
// - Stretched high ends the address phase.
// - Registers are write-only; no read path.
// - Writes to locations 03h and 04h ignored.
// - Shutdown returns all registers to defaults.
// - Receiver stays active during sleep.
module pulse_count_write_interface #(
  parameter int CNT_W = 20,
  parameter int ENABLE_CYC = pcw_pkg::ENABLE_HIGH_CYC,
  parameter int DISABLE_CYC = pcw_pkg::DISABLE_LOW_CYC,
  parameter int ADDR_MIN_CYC = pcw_pkg::ADDR_HOLD_MIN_CYC,
  parameter int ADDR_MAX_CYC = pcw_pkg::ADDR_HOLD_MAX_CYC,
  parameter int DATA_CYC = pcw_pkg::DATA_HOLD_CYC,
  parameter int STANDBY_CYC = pcw_pkg::STANDBY_CYC
) (
  input wire logic I_CLK,
  input wire logic I_RST,
  input wire logic I_SERIAL_PULSE_PIN,
  output logic [5:0] O_SINK_ENABLE_BITS,
  output logic [5:0] O_PRIMARY_BANK_CURRENT,
  output logic [5:0] O_SECONDARY_BANK_CURRENT,
  output logic [5:0] O_REGULATOR_ONE_VOLTAGE,
  output logic [5:0] O_REGULATOR_TWO_VOLTAGE,
  output logic [5:0] O_REGULATOR_THREE_VOLTAGE,
  output logic [5:0] O_REGULATOR_FOUR_VOLTAGE,
  output logic [5:0] O_BANK_RAMP_CONTROL,
  output logic [5:0] O_BANK_ASSIGNMENT,
  output logic O_DEVICE_ENABLED,
  output logic O_SLEEP
);

  // ------------------------------------------------------------------
  // Elaboration checks
  // ------------------------------------------------------------------
  if (ENABLE_CYC < 1 || DISABLE_CYC < 1 || ADDR_MIN_CYC < 1 ||
      DATA_CYC < 1 || ADDR_MAX_CYC <= ADDR_MIN_CYC ||
      STANDBY_CYC <= ADDR_MAX_CYC || STANDBY_CYC <= DATA_CYC ||
      STANDBY_CYC >= (1 << CNT_W) - 1 ||
      DISABLE_CYC >= (1 << CNT_W) - 1) begin : g_chk
    $error("pulse_count_write_interface: bad timing parameters");
  end

  localparam logic [CNT_W-1:0] CNT_ZERO = '0;
  localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);
  localparam logic [CNT_W-1:0] CNT_SAT = '1;

  // ------------------------------------------------------------------
  // Line sampling and interval timers
  // ------------------------------------------------------------------
  logic pin_r;
  logic pin_q_r;
  logic [CNT_W-1:0] hi_cnt_r;
  logic [CNT_W-1:0] lo_cnt_r;
  logic rise;

  // Idle level is high, so both stages reset high to avoid a false edge
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      pin_r <= 1'b1;
      pin_q_r <= 1'b1;
    end else begin
      pin_r <= I_SERIAL_PULSE_PIN;
      pin_q_r <= pin_r;
    end
  end

  assign rise = pin_r && !pin_q_r;

  // Only high and low durations are timed; pulse width is free
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      hi_cnt_r <= CNT_ZERO;
    end else if (!pin_r) begin
      hi_cnt_r <= CNT_ZERO;
    end else if (hi_cnt_r != CNT_SAT) begin
      hi_cnt_r <= hi_cnt_r + CNT_ONE;
    end
  end

  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      lo_cnt_r <= CNT_ZERO;
    end else if (pin_r) begin
      lo_cnt_r <= CNT_ZERO;
    end else if (lo_cnt_r != CNT_SAT) begin
      lo_cnt_r <= lo_cnt_r + CNT_ONE;
    end
  end

  logic en_hit;
  logic dis_hit;
  logic amin_hit;
  logic amax_hit;
  logic dhold_hit;
  logic stby_hit;

  assign en_hit = pin_r && hi_cnt_r == CNT_W'(ENABLE_CYC);
  assign dis_hit = !pin_r && lo_cnt_r == CNT_W'(DISABLE_CYC);
  assign amin_hit = pin_r && hi_cnt_r == CNT_W'(ADDR_MIN_CYC);
  assign amax_hit = pin_r && hi_cnt_r == CNT_W'(ADDR_MAX_CYC);
  assign dhold_hit = pin_r && hi_cnt_r == CNT_W'(DATA_CYC);
  assign stby_hit = pin_r && hi_cnt_r == CNT_W'(STANDBY_CYC);

  // ------------------------------------------------------------------
  // Device enable
  // ------------------------------------------------------------------
  logic en_r;

  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      en_r <= 1'b0;
    end else if (!en_r && en_hit) begin
      en_r <= 1'b1;
    end else if (en_r && dis_hit) begin
      en_r <= 1'b0;
    end
  end

  // ------------------------------------------------------------------
  // Pulse-train receiver
  // ------------------------------------------------------------------
  pcw_pkg::phase_t phase_r;
  logic [pcw_pkg::EDGE_W-1:0] edge_cnt_r;
  logic [pcw_pkg::EDGE_W-1:0] edge_limit;
  logic ovf_r;
  logic [pcw_pkg::ADDR_W-1:0] addr_r;
  logic have_edges;
  logic addr_done;
  logic addr_abandon;
  logic data_done;
  logic rx_flush;

  assign edge_limit = (phase_r == pcw_pkg::PH_ADDR) ?
                      pcw_pkg::ADDR_EDGE_MAX : pcw_pkg::DATA_EDGE_MAX;
  assign have_edges = edge_cnt_r != pcw_pkg::EDGE_NONE;
  // Receiver runs whatever the sinks do, so sleep never deafens it
  assign rx_flush = !en_r || stby_hit;
  // Stretched high ends address phase
  assign addr_done = phase_r == pcw_pkg::PH_ADDR && amin_hit && have_edges;
  assign addr_abandon = phase_r == pcw_pkg::PH_DATA && amax_hit &&
                        !have_edges;
  assign data_done = phase_r == pcw_pkg::PH_DATA && dhold_hit &&
                     have_edges;

  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      phase_r <= pcw_pkg::PH_ADDR;
      edge_cnt_r <= pcw_pkg::EDGE_NONE;
      ovf_r <= 1'b0;
      addr_r <= '0;
    end else if (rx_flush) begin
      phase_r <= pcw_pkg::PH_ADDR;
      edge_cnt_r <= pcw_pkg::EDGE_NONE;
      ovf_r <= 1'b0;
    end else if (rise) begin
      // Highs shorter than a hold and lows shorter than a disable just keep the count going
      if (edge_cnt_r == edge_limit) begin
        ovf_r <= 1'b1;
      end else begin
        edge_cnt_r <= edge_cnt_r + 7'h01;
      end
    end else if (addr_done) begin
      edge_cnt_r <= pcw_pkg::EDGE_NONE;
      ovf_r <= 1'b0;
      if (!ovf_r) begin
        addr_r <= pcw_pkg::ADDR_W'(edge_cnt_r - 7'h01);
        phase_r <= pcw_pkg::PH_DATA;
      end
    end else if (addr_abandon || data_done) begin
      phase_r <= pcw_pkg::PH_ADDR;
      edge_cnt_r <= pcw_pkg::EDGE_NONE;
      ovf_r <= 1'b0;
    end
  end

  // ------------------------------------------------------------------
  // Write strobe toward the register bank
  // ------------------------------------------------------------------
  logic we_r;
  logic [pcw_pkg::ADDR_W-1:0] waddr_r;
  logic [pcw_pkg::DATA_W-1:0] wdata_r;

  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      we_r <= 1'b0;
      waddr_r <= '0;
      wdata_r <= '0;
    end else begin
      // Overflowed data trains never write
      we_r <= !rx_flush && data_done && !ovf_r;
      waddr_r <= addr_r;
      wdata_r <= pcw_pkg::DATA_W'(edge_cnt_r - 7'h01);
    end
  end

  // ------------------------------------------------------------------
  // Register bank, write-only toward the link
  // ------------------------------------------------------------------
  logic [pcw_pkg::REG_DEPTH-1:0][pcw_pkg::DATA_W-1:0] regs;

  // Holes are decoded out inside the bank
  ctrl_reg_bank #(
    .ADDR_W(pcw_pkg::ADDR_W),
    .DATA_W(pcw_pkg::DATA_W),
    .DEPTH(pcw_pkg::REG_DEPTH)
  ) u_bank (
    .i_clk(I_CLK),
    .i_rst(I_RST),
    .i_clear(en_r && dis_hit),
    .i_we(we_r),
    .i_addr(waddr_r),
    .i_data(wdata_r),
    .o_regs(regs)
  );

  // Bank contents go straight out; nothing reads them back
  assign O_SINK_ENABLE_BITS = regs[pcw_pkg::SINK_ENABLE_BITS_ADDR];
  assign O_PRIMARY_BANK_CURRENT = regs[pcw_pkg::PRIMARY_BANK_CURRENT_ADDR];
  assign O_SECONDARY_BANK_CURRENT =
    regs[pcw_pkg::SECONDARY_BANK_CURRENT_ADDR];
  assign O_REGULATOR_ONE_VOLTAGE = regs[pcw_pkg::REGULATOR_ONE_VOLTAGE_ADDR];
  assign O_REGULATOR_TWO_VOLTAGE = regs[pcw_pkg::REGULATOR_TWO_VOLTAGE_ADDR];
  assign O_REGULATOR_THREE_VOLTAGE =
    regs[pcw_pkg::REGULATOR_THREE_VOLTAGE_ADDR];
  assign O_REGULATOR_FOUR_VOLTAGE =
    regs[pcw_pkg::REGULATOR_FOUR_VOLTAGE_ADDR];
  assign O_BANK_RAMP_CONTROL = regs[pcw_pkg::BANK_RAMP_CONTROL_ADDR];
  assign O_BANK_ASSIGNMENT = regs[pcw_pkg::BANK_ASSIGNMENT_ADDR];
  assign O_DEVICE_ENABLED = en_r;

  // Sleep flag lags the sink register by one cycle
  logic sleep_r;

  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      sleep_r <= 1'b0;
    end else begin
      sleep_r <= en_r &&
        regs[pcw_pkg::SINK_ENABLE_BITS_ADDR] == pcw_pkg::REG_RESET_VALUE;
    end
  end

  assign O_SLEEP = sleep_r;

  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  default clocking cb @(posedge I_CLK);
  endclocking
  default disable iff (I_RST);

  sequence s_data_taken;
    data_done && !ovf_r && en_r && !stby_hit;
  endsequence

  sequence s_strobe(logic [4:0] a, logic [5:0] d);
    we_r && waddr_r == a && wdata_r == d;
  endsequence

  enable_set_a: assert property (
    !en_r && en_hit |=> en_r && O_DEVICE_ENABLED)
    else $error("device not enabled after long high");

  disable_clear_a: assert property (
    en_r && dis_hit |=> !en_r)
    else $error("device not disabled after long low");

  shutdown_regs_a: assert property (
    $fell(en_r) |-> regs == '0)
    else $error("registers not at default after shutdown");

  addr_latch_a: assert property (
    en_r && !stby_hit && addr_done && !ovf_r && !rise
    |=> phase_r == pcw_pkg::PH_DATA &&
        addr_r == pcw_pkg::ADDR_W'($past(edge_cnt_r) - 7'h01))
    else $error("address not latched as edges minus one");

  addr_discard_a: assert property (
    en_r && !stby_hit && addr_done && ovf_r
    |=> phase_r == pcw_pkg::PH_ADDR && edge_cnt_r == pcw_pkg::EDGE_NONE
        && !ovf_r)
    else $error("overflowed address not discarded");

  addr_overhold_a: assert property (
    en_r && addr_abandon |=> phase_r == pcw_pkg::PH_ADDR)
    else $error("overlong address hold not abandoned");

  data_write_a: assert property (
    s_data_taken |=> s_strobe($past(addr_r),
      pcw_pkg::DATA_W'($past(edge_cnt_r) - 7'h01)))
    else $error("data write strobe wrong or missing");

  write_lands_a: assert property (
    we_r && waddr_r == pcw_pkg::PRIMARY_BANK_CURRENT_ADDR
    |=> O_PRIMARY_BANK_CURRENT == ($past(wdata_r) & pcw_pkg::MASK_LEVEL))
    else $error("written value not stored");

  hole_ignored_a: assert property (
    we_r && (waddr_r == pcw_pkg::UNUSED_LOW_ADDR ||
             waddr_r == pcw_pkg::UNUSED_HIGH_ADDR) && !dis_hit
    |=> $stable(regs))
    else $error("write to unused location changed state");

  ovf_set_a: assert property (
    en_r && !stby_hit && rise && edge_cnt_r == edge_limit
    |=> ovf_r ##0 !we_r)
    else $error("edge overflow not flagged");

  ovf_nowrite_a: assert property (
    data_done && ovf_r |=> !we_r ##1 phase_r == pcw_pkg::PH_ADDR)
    else $error("overflowed data was written");

  data_to_addr_a: assert property (
    en_r && data_done |=> phase_r == pcw_pkg::PH_ADDR &&
                          edge_cnt_r == pcw_pkg::EDGE_NONE)
    else $error("receiver not back to address phase");

  standby_a: assert property (
    stby_hit |=> phase_r == pcw_pkg::PH_ADDR && !ovf_r &&
                 edge_cnt_r == pcw_pkg::EDGE_NONE)
    else $error("standby did not reset receiver");

  edge_count_a: assert property (
    en_r && !stby_hit && rise && edge_cnt_r != edge_limit
    |=> edge_cnt_r == $past(edge_cnt_r) + 7'h01)
    else $error("rising edge not counted");

endmodule

//--- test/pcw_host_model.sv
`timescale 1ns/10ps
module pcw_host_model #(
  parameter int ENABLE_CYC = 4,
  parameter int DISABLE_CYC = 20,
  parameter int ADDR_MIN_CYC = 10,
  parameter int DATA_CYC = 10,
  parameter int STANDBY_CYC = 40
) (
  input wire logic i_clk,
  output logic o_line
);
  // ------------------------------------------------------------
  // Line drive
  // ------------------------------------------------------------
  // Push-pull host, idle high; never released
  initial o_line = 1'b1;

  task automatic level(input logic v, input int n);
    o_line <= v;
    repeat (n) @(posedge i_clk);
  endtask

  // Jittered widths stay below the shortest hold threshold
  // Last high stays short: it merges into the hold that follows,
  // and a long one would push that hold past its upper limit
  task automatic train(input int n, input bit jit);
    for (int i = 0; i < n; i++) begin
      level(1'b0, jit ? 1 + i % 3 : 2);
      level(1'b1, (jit && i < n - 1) ? 1 + (i % 5) * 2 : 2);
    end
  endtask

  // ------------------------------------------------------------
  // Commands
  // ------------------------------------------------------------
  // Address always sent with its data
  task automatic write(input int a, input int d, input bit jit);
    train(a + 1, jit);
    level(1'b1, ADDR_MIN_CYC + 3);
    train(d + 1, jit);
    level(1'b1, DATA_CYC + 5);
  endtask

  task automatic enable();
    level(1'b1, ENABLE_CYC + 5);
  endtask

  task automatic shutdown();
    level(1'b0, DISABLE_CYC + 5);
  endtask

  task automatic standby();
    level(1'b1, STANDBY_CYC + 5);
  endtask
endmodule

//--- test/pulse_count_write_interface_tb_top.sv
`timescale 1ns/10ps
module pulse_count_write_interface_tb_top;
  localparam int EN = 4;
  localparam int DIS = 20;
  localparam int AMIN = 10;
  localparam int AMAX = 20;
  localparam int DH = 10;
  localparam int SB = 40;
  localparam int LIMIT = 40000;
  // Writable bits per location; 03h and 04h hold nothing
  localparam logic [5:0] MSK [0:10] = '{6'h3f, 6'h1f, 6'h1f, 6'h00,
    6'h00, 6'h0f, 6'h07, 6'h0f, 6'h0f, 6'h3f, 6'h07};

  logic clk;
  logic rst;
  logic line;
  logic en;
  logic slp;
  logic [5:0] q [0:10];
  logic [5:0] exp_r [0:10];
  int n_errors = 0;
  int num_checks = 0;
  int cycles = 0;

  pulse_count_write_interface #(.ENABLE_CYC(EN), .DISABLE_CYC(DIS),
    .ADDR_MIN_CYC(AMIN), .ADDR_MAX_CYC(AMAX), .DATA_CYC(DH),
    .STANDBY_CYC(SB)) dut (
    .I_CLK(clk),
    .I_RST(rst),
    .I_SERIAL_PULSE_PIN(line),
    .O_SINK_ENABLE_BITS(q[0]),
    .O_PRIMARY_BANK_CURRENT(q[1]),
    .O_SECONDARY_BANK_CURRENT(q[2]),
    .O_REGULATOR_ONE_VOLTAGE(q[5]),
    .O_REGULATOR_TWO_VOLTAGE(q[6]),
    .O_REGULATOR_THREE_VOLTAGE(q[7]),
    .O_REGULATOR_FOUR_VOLTAGE(q[8]),
    .O_BANK_RAMP_CONTROL(q[9]),
    .O_BANK_ASSIGNMENT(q[10]),
    .O_DEVICE_ENABLED(en),
    .O_SLEEP(slp)
  );

  pcw_host_model #(.ENABLE_CYC(EN), .DISABLE_CYC(DIS),
    .ADDR_MIN_CYC(AMIN), .DATA_CYC(DH), .STANDBY_CYC(SB)) host (
    .i_clk(clk),
    .o_line(line)
  );

  // ------------------------------------------------------------
  // Clock, watchdog, report
  // ------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      n_errors++;
      final_report();
    end
  end

  task automatic final_report();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // ------------------------------------------------------------
  // Checking helpers
  // ------------------------------------------------------------
  task automatic chk(input string nm, input logic [5:0] e,
                     input logic [5:0] s);
    num_checks++;
    if (s !== e) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", nm, e, s);
    end
  endtask

  // Lets the store land, compares off-edge, resyncs to a rising edge
  task automatic look(input string nm, input logic e_en,
                      input logic e_slp);
    repeat (2) @(posedge clk);
    @(negedge clk);
    for (int a = 0; a < 11; a++) begin
      if (a != 3 && a != 4) begin
        chk($sformatf("%s reg%0d", nm, a), exp_r[a], q[a]);
      end
    end
    chk({nm, " enabled"}, {5'h00, e_en}, {5'h00, en});
    chk({nm, " sleep"}, {5'h00, e_slp}, {5'h00, slp});
    @(posedge clk);
  endtask

  // Host sends only zero reserved bits, so stored value is d
  task automatic wr(input int a, input int d, input bit jit);
    host.write(a, d, jit);
    if (a < 11 && MSK[a] != 6'h00) begin
      exp_r[a] = 6'(d);
    end
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_all_regs();
    for (int a = 0; a < 11; a++) begin
      // Holes get a nonzero value so a stray decode would show
      wr(a, int'((MSK[a] == 6'h00 ? 6'h3f : MSK[a]) & (6'h15 + 6'(a))),
         1'b0);
    end
    look("map", 1'b1, 1'b0);
    wr(0, 63, 1'b0);
    wr(10, 0, 1'b0);
    wr(31, 5, 1'b0);
    wr(1, 5, 1'b0);
    wr(1, 9, 1'b0);
    look("bounds", 1'b1, 1'b0);
  endtask

  task automatic t_addr_over();
    host.train(33, 1'b0);
    host.level(1'b1, AMIN + 3);
    wr(2, 4, 1'b0);
    look("addr over", 1'b1, 1'b0);
  endtask

  task automatic t_data_over();
    host.train(3, 1'b0);
    host.level(1'b1, AMIN + 3);
    host.train(65, 1'b0);
    host.level(1'b1, DH + 5);
    look("data over", 1'b1, 1'b0);
    wr(5, 3, 1'b0);
    look("after over", 1'b1, 1'b0);
  endtask

  task automatic t_addr_late();
    host.train(2, 1'b0);
    host.level(1'b1, AMAX + 5);
    wr(6, 2, 1'b0);
    look("addr late", 1'b1, 1'b0);
  endtask

  task automatic t_jitter();
    wr(7, 11, 1'b1);
    wr(9, 33, 1'b1);
    look("jitter", 1'b1, 1'b0);
  endtask

  // A stretched high splits the address train into address and data
  task automatic t_stretch();
    host.train(3, 1'b0);
    host.level(1'b1, AMIN + 3);
    host.train(3, 1'b0);
    host.level(1'b1, AMIN + 3);
    exp_r[2] = 6'h02;
    host.train(4, 1'b0);
    host.standby();
    look("stretch", 1'b1, 1'b0);
    wr(8, 5, 1'b0);
    look("standby", 1'b1, 1'b0);
  endtask

  task automatic t_shutdown();
    host.shutdown();
    for (int a = 0; a < 11; a++) begin
      exp_r[a] = 6'h00;
    end
    look("shutdown", 1'b0, 1'b0);
    host.enable();
    look("reenable", 1'b1, 1'b1);
    wr(1, 17, 1'b0);
    look("sleep write", 1'b1, 1'b1);
  endtask

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    rst = 1'b1;
    for (int a = 0; a < 11; a++) begin
      exp_r[a] = 6'h00;
    end
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    look("reset", 1'b0, 1'b0);
    host.enable();
    look("enable", 1'b1, 1'b1);
    t_all_regs();
    t_addr_over();
    t_data_over();
    t_addr_late();
    t_jitter();
    t_stretch();
    t_shutdown();
    final_report();
  end
endmodule
